/* focls_classifier.sv */
// focls_classifier: operand front end of the float unit, registered outputs.
// assumes opcode and operands come from same-clock pipeline logic, one op per cycle.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - split operand into sign, exponent, integer, fraction
// - max exponent, integer zero, fraction set: pseudo-NaN
// - detect pseudo-infinity and unnormal encodings
// - unsupported encodings raise invalid, suppress computing
// - pseudo-denormal treated as denormal, denormal raised
// - never emit a pseudo-denormal result
// - opcodes D8 through DF go to float unit
// - one or two operands, stack or memory
// - no immediate extracted for float opcodes
// - register index is relative to stack top
// - masked short denormal normalized on widening
module focls_classifier (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic                      instValid,
  input  wire logic [7:0]                opcodeByte,
  input  wire logic                      twoOperands,
  input  wire focls_pkg::focls_src_t     srcA,
  input  wire focls_pkg::focls_src_t     srcB,
  input  wire focls_pkg::focls_opnd_t    opndA,
  input  wire focls_pkg::focls_opnd_t    opndB,
  input  wire logic [focls_pkg::REG_IDX_W-1:0] stackTop,
  input  wire logic                      shortDenormSrc,
  input  wire logic                      denormMasked,
  input  wire focls_pkg::focls_opnd_t    resultIn,
  input  wire logic                      flagsClear,
  output logic                           floatOpValid,
  output logic                           immExtract,
  output focls_pkg::focls_res_t          resA,
  output focls_pkg::focls_res_t          resB,
  output logic [focls_pkg::REG_IDX_W-1:0] physIdxA,
  output logic [focls_pkg::REG_IDX_W-1:0] physIdxB,
  output logic                           opndBUsed,
  output logic                           computeEn,
  output logic                           normalizeReq,
  output focls_pkg::focls_opnd_t         resultOut,
  output focls_pkg::focls_flags_t        statusFlags
);
  import focls_pkg::*;

  // ----------------------------------------------------------------
  // classification function
  // ----------------------------------------------------------------
  function automatic focls_res_t classify(input focls_opnd_t op);
    focls_res_t r;
    logic expMax;
    logic expMin;
    logic fracNz;
    r = '0;
    expMax = (op.exponent == EXP_ONES);
    expMin = (op.exponent == EXP_ZERO);
    fracNz = (op.fraction != FRAC_ZERO);
    // max-exponent cases are tested first, so a missing integer bit there
    // reads as pseudo-NaN or pseudo-infinity and never as unnormal
    r.cls = CLS_NORMAL;
    if (expMax && !op.intBit && fracNz) begin
      r.cls      = CLS_PSEUDONAN;
      r.quietNan = op.fraction[FRAC_TOP];
    end else if (expMax && !op.intBit) begin
      r.cls = CLS_PSEUDOINF;
    end else if (expMax && fracNz) begin
      r.cls      = CLS_NAN;
      r.quietNan = op.fraction[FRAC_TOP];
    end else if (expMax) begin
      r.cls = CLS_INFINITY;
    end else if (expMin && op.intBit) begin
      r.cls = CLS_PSEUDODEN;
    end else if (expMin && fracNz) begin
      r.cls = CLS_DENORMAL;
    end else if (expMin) begin
      r.cls = CLS_ZERO;
    end else if (!op.intBit) begin
      r.cls = CLS_UNNORMAL;
    end
    // legacy encodings other than pseudo-denormal are refused rather than computed on
    r.invalid  = (r.cls == CLS_PSEUDONAN) || (r.cls == CLS_PSEUDOINF)
              || (r.cls == CLS_UNNORMAL);
    // a signaling true NaN is also an invalid operand
    r.invalid  = r.invalid || ((r.cls == CLS_NAN) && !r.quietNan);
    r.denormal = (r.cls == CLS_PSEUDODEN) || (r.cls == CLS_DENORMAL);
    return r;
  endfunction : classify

  // ----------------------------------------------------------------
  // combinational decode and classification
  // ----------------------------------------------------------------
  // everything here settles within the cycle the operand is presented
  logic                 isFloatOp;
  focls_opnd_t          opndV [2];
  focls_src_t           srcV  [2];
  logic                 useV  [2];
  focls_res_t           clsV  [2];
  logic [REG_IDX_W-1:0] idxV  [2];
  focls_res_t           clsA;
  focls_res_t           clsB;
  logic                 anyInvalid;
  logic                 anyDenormal;
  logic                 resultPseudoDen;

  // escape group is a contiguous range of eight first bytes
  assign isFloatOp   = instValid && (opcodeByte >= FLOAT_OP_LO)
                     && (opcodeByte <= FLOAT_OP_HI);

  // operand slots; B only counts when the instruction names a second operand
  assign opndV[0] = opndA;
  assign opndV[1] = opndB;
  assign srcV[0]  = srcA;
  assign srcV[1]  = srcB;
  assign useV[0]  = 1'b1;
  assign useV[1]  = twoOperands;

  // one classifier and one index adder per slot
  for (genvar g = 0; g < 2; g++) begin : g_slot
    assign clsV[g] = classify(opndV[g]);
    // the stack wraps mod eight, so the carry of the add is dropped on purpose
    assign idxV[g] = (srcV[g].fromMem || !useV[g]) ? IDX_ZERO
                   : REG_IDX_W'(stackTop + srcV[g].stackIdx);
  end

  assign clsA        = clsV[0];
  assign clsB        = clsV[1];
  // flags gather A, B when present, and a widened short denormal
  assign anyInvalid  = isFloatOp && (clsA.invalid || (twoOperands && clsB.invalid));
  assign anyDenormal = isFloatOp && (clsA.denormal || (twoOperands && clsB.denormal)
                     || shortDenormSrc);
  // a result in the pseudo-denormal encoding must not leave the unit
  assign resultPseudoDen = (resultIn.exponent == EXP_ZERO) && resultIn.intBit;

  // ----------------------------------------------------------------
  // decode outputs
  // ----------------------------------------------------------------
  // registered so every output comes from a flip-flop
  // other opcodes still pass through; they just leave floatOpValid and opndBUsed low
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      floatOpValid <= 1'b0;
      immExtract   <= 1'b0;
      opndBUsed    <= 1'b0;
    end else begin
      floatOpValid <= isFloatOp;
      // float group never carries an immediate; others left to the main decoder
      immExtract   <= 1'b0;
      opndBUsed    <= isFloatOp && twoOperands;
    end
  end

  // ----------------------------------------------------------------
  // operand source resolution
  // ----------------------------------------------------------------
  // index wraps mod eight around the stack top; memory sources report zero
  // zero for memory keeps the output defined though no stack slot is used
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      physIdxA <= IDX_ZERO;
      physIdxB <= IDX_ZERO;
    end else begin
      physIdxA <= idxV[0];
      physIdxB <= idxV[1];
    end
  end

  // ----------------------------------------------------------------
  // classification results and compute gate
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      resA         <= '{cls: CLS_ZERO, default: 1'b0};
      resB         <= '{cls: CLS_ZERO, default: 1'b0};
      computeEn    <= 1'b0;
      normalizeReq <= 1'b0;
    end else begin
      resA         <= clsA;
      resB         <= twoOperands ? clsB : '{cls: CLS_ZERO, default: 1'b0};
      // a low computeEn is how the unit refuses to work on a bad operand
      computeEn    <= isFloatOp && !anyInvalid;
      // widening normalizes only when software has masked the exception
      normalizeReq <= isFloatOp && shortDenormSrc && denormMasked;
    end
  end

  // ----------------------------------------------------------------
  // result guard
  // ----------------------------------------------------------------
  // a pseudo-denormal result is rewritten to the equal-valued normal with exponent one
  // the core is not told of the rewrite; only the encoding changes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      resultOut <= '0;
    end else if (resultPseudoDen) begin
      resultOut          <= resultIn;
      resultOut.exponent <= EXP_MIN_NORM;
    end else begin
      resultOut <= resultIn;
    end
  end

  // ----------------------------------------------------------------
  // sticky status flags
  // ----------------------------------------------------------------
  // set wins over clear so an event in the clearing cycle survives
  // the denormal flag rises whatever the mask; the mask only decides
  // whether a widened short denormal is normalized
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      statusFlags <= '0;
    end else begin
      statusFlags.invalid  <= anyInvalid
                            || (statusFlags.invalid && !flagsClear);
      statusFlags.denormal <= anyDenormal
                            || (statusFlags.denormal && !flagsClear);
    end
  end

endmodule : focls_classifier
`default_nettype wire

/* focls_pkg.sv */
// focls_pkg: constants, field layouts and carrier types for the float operand classifier.
// assumes one core clock domain; shared by the classifier and its testbench.
package focls_pkg;

  // ----------------------------------------------------------------
  // operand field layout
  // ----------------------------------------------------------------
  localparam int EXP_W   = 15;
  localparam int FRAC_W  = 63;
  localparam int OPND_W  = 80;
  localparam int REG_IDX_W = 3;

  localparam logic [EXP_W-1:0]  EXP_ZERO  = 15'h0000;
  localparam logic [EXP_W-1:0]  EXP_ONES  = 15'h7FFF;
  localparam logic [FRAC_W-1:0] FRAC_ZERO = 63'h0000_0000_0000_0000;
  localparam int FRAC_TOP = FRAC_W - 1;
  // smallest normal exponent, used when a result must leave the denormal range
  localparam logic [EXP_W-1:0]  EXP_MIN_NORM = 15'h0001;

  // escape opcode group bounds, inclusive
  localparam logic [7:0] FLOAT_OP_LO = 8'hD8;
  localparam logic [7:0] FLOAT_OP_HI = 8'hDF;

  localparam logic [REG_IDX_W-1:0] IDX_ZERO = 3'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              sign;
    logic [EXP_W-1:0]  exponent;
    logic              intBit;
    logic [FRAC_W-1:0] fraction;
  } focls_opnd_t;

  // one-hot operand class codes
  typedef enum logic [8:0] {
    CLS_ZERO      = 9'h001,
    CLS_DENORMAL  = 9'h002,
    CLS_PSEUDODEN = 9'h004,
    CLS_NORMAL    = 9'h008,
    CLS_UNNORMAL  = 9'h010,
    CLS_INFINITY  = 9'h020,
    CLS_PSEUDOINF = 9'h040,
    CLS_NAN       = 9'h080,
    CLS_PSEUDONAN = 9'h100
  } focls_class_t;

  // operand source selection from the decoder
  typedef struct packed {
    logic                 fromMem;
    logic [REG_IDX_W-1:0] stackIdx;
  } focls_src_t;

  // per-operand classification result
  typedef struct packed {
    focls_class_t cls;
    logic         quietNan;
    logic         invalid;
    logic         denormal;
  } focls_res_t;

  // sticky exception flags as kept in the status word
  typedef struct packed {
    logic invalid;
    logic denormal;
  } focls_flags_t;

endpackage : focls_pkg

/* focls_classifier_properties.sv */
// focls_classifier_properties: port checks on the classifier.
// assumes binding into focls_classifier; one clock, sync active-low reset.
`timescale 1ns/100ps
`default_nettype none
module focls_chk (
  input wire logic                    core_clk,
  input wire logic                    rst_n,
  input wire logic                    instValid,
  input wire logic [7:0]              opcodeByte,
  input wire focls_pkg::focls_src_t   srcA,
  input wire focls_pkg::focls_opnd_t  opndA,
  input wire logic [2:0]              stackTop,
  input wire logic                    floatOpValid,
  input wire logic                    immExtract,
  input wire focls_pkg::focls_res_t   resA,
  input wire logic [2:0]              physIdxA,
  input wire logic                    computeEn,
  input wire focls_pkg::focls_opnd_t  resultOut,
  input wire focls_pkg::focls_flags_t statusFlags
);
  import focls_pkg::*;
  // operand A decode, sampled one cycle back in the properties
  wire logic fop = instValid && opcodeByte >= FLOAT_OP_LO && opcodeByte <= FLOAT_OP_HI;
  wire logic eOn = opndA.exponent == EXP_ONES;
  wire logic eZr = opndA.exponent == EXP_ZERO;
  wire logic fNz = opndA.fraction != FRAC_ZERO;
  wire logic pNan = eOn && !opndA.intBit && fNz;
  wire logic pInf = eOn && !opndA.intBit && !fNz;
  wire logic unNm = !eOn && !eZr && !opndA.intBit;
  wire logic pDen = eZr && opndA.intBit;
  wire logic bad3 = pNan || pInf || unNm;
  wire logic qBit = opndA.fraction[FRAC_TOP];
  wire logic [2:0] sIdx = stackTop + srcA.stackIdx;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_float_group: assert property ($past(rst_n) |-> floatOpValid == $past(fop))
    else $error("float group flag wrong");
  a_no_immediate: assert property (!immExtract)
    else $error("immediate extracted");
  a_pseudo_nan: assert property ($past(rst_n) && $past(pNan)
    |-> resA.cls == CLS_PSEUDONAN && resA.quietNan == $past(qBit)) else $error("pseudo nan");
  a_pseudo_inf: assert property ($past(rst_n) && $past(pInf)
    |-> resA.cls == CLS_PSEUDOINF) else $error("pseudo inf");
  a_unnormal_cls: assert property ($past(rst_n) && $past(unNm)
    |-> resA.cls == CLS_UNNORMAL) else $error("unnormal");
  a_invalid_raise: assert property ($past(rst_n) && $past(bad3) |-> resA.invalid)
    else $error("invalid not raised");
  a_pseudo_den: assert property ($past(rst_n) && $past(pDen)
    |-> resA.cls == CLS_PSEUDODEN && resA.denormal && !resA.invalid) else $error("pseudo den");
  a_no_pden_out: assert property (!(resultOut.exponent == EXP_ZERO && resultOut.intBit))
    else $error("pseudo denormal result");
  a_stack_rel: assert property ($past(rst_n) && floatOpValid && !$past(srcA.fromMem)
    |-> physIdxA == $past(sIdx)) else $error("stack index");
  a_flag_block: assert property (floatOpValid && resA.invalid
    |-> !computeEn && statusFlags.invalid) else $error("invalid not blocking");
  // main scenarios reached
  c_pseudo_nan: cover property (floatOpValid && resA.cls == CLS_PSEUDONAN);
  c_flag_clear: cover property ($fell(statusFlags.invalid));
  c_blocked: cover property (floatOpValid && !computeEn);
endmodule : focls_chk
bind focls_classifier focls_chk u_chk (
  .core_clk     (core_clk),
  .rst_n        (rst_n),
  .instValid    (instValid),
  .opcodeByte   (opcodeByte),
  .srcA         (srcA),
  .opndA        (opndA),
  .stackTop     (stackTop),
  .floatOpValid (floatOpValid),
  .immExtract   (immExtract),
  .resA         (resA),
  .physIdxA     (physIdxA),
  .computeEn    (computeEn),
  .resultOut    (resultOut),
  .statusFlags  (statusFlags)
);
`default_nettype wire

/* focls_core_model.sv */
// focls_core_model: arithmetic core stand-in feeding results back.
// assumes the bench seeds $urandom; pseudoDen asks for a legacy encoding.
`timescale 1ns/100ps
`default_nettype none
module focls_core_model (
  input  wire logic                  core_clk,
  input  wire logic                  pseudoDen,
  output var focls_pkg::focls_opnd_t resultIn
);
  import focls_pkg::*;
  initial resultIn = '0;
  // a clean core keeps to supported encodings unless told otherwise
  always @(posedge core_clk) begin
    resultIn <= {1'($urandom), pseudoDen ? EXP_ZERO : 15'h3FFF, 1'b1, 63'({$urandom, $urandom})};
  end
endmodule : focls_core_model
`default_nettype wire

/* tb_top.sv */
// tb_top: self-checking bench for focls_classifier, queued scoreboard.
// assumes package, core model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import focls_pkg::*;
  typedef struct packed {
    int due; logic fop; focls_class_t ca; focls_class_t cb; logic [2:0] pa; logic ce; logic fi;
    logic [2:0] pb; logic ub; logic nr; logic fd; logic [2:0] fa;
  } focls_note_t;
  logic fDen = 0, rDue = 0;
  logic core_clk = 0, rst_n = 0, instValid, twoOperands, shortDenormSrc, denormMasked;
  logic flagsClear, pseudoDen, fInv = 0, floatOpValid, immExtract, opndBUsed, computeEn;
  logic normalizeReq;
  logic [7:0] opcodeByte;
  logic [2:0] stackTop, physIdxA, physIdxB;
  focls_src_t srcA, srcB;
  focls_opnd_t opndA, opndB, resultIn, resultOut, rPrev, rExp;
  focls_res_t resA, resB;
  focls_flags_t statusFlags;
  focls_note_t q[$], e;
  logic [7:0] ops [5] = '{8'hD7, 8'hD8, 8'hDB, 8'hDF, 8'hE0};
  int cyc = 0, n_fail = 0, total_checks = 0;
  focls_classifier dut (.core_clk, .rst_n, .instValid, .opcodeByte, .twoOperands, .srcA, .srcB,
    .opndA, .opndB, .stackTop, .shortDenormSrc, .denormMasked, .resultIn, .flagsClear,
    .floatOpValid, .immExtract, .resA, .resB, .physIdxA, .physIdxB, .opndBUsed, .computeEn,
    .normalizeReq, .resultOut, .statusFlags);
  focls_core_model u_core (.core_clk, .pseudoDen, .resultIn);
  // 250 MHz core clock
  always #2 core_clk = ~core_clk;
  // random operand of class c, in one-hot class order
  function automatic focls_opnd_t mk(int c);
    focls_opnd_t o;
    o = 80'({$urandom, $urandom, $urandom});
    o.intBit = c inside {2, 3, 5, 7};
    o.exponent = c < 3 ? EXP_ZERO : c < 5 ? {2'h0, o.exponent[12:1], 1'b1} : EXP_ONES;
    if (c inside {0, 5, 6}) o.fraction = FRAC_ZERO;
    if (c inside {1, 7, 8}) o.fraction[0] = 1'b1;
    return o;
  endfunction : mk
  // unsupported encodings and signaling nan are invalid
  function automatic logic bad(int c, focls_opnd_t o);
    return c inside {4, 6, 8} || (c == 7 && !o.fraction[FRAC_TOP]);
  endfunction : bad
  // drive one instruction and note what must show one cycle later
  task automatic step(logic iv, logic [7:0] op, int ca, int cb, logic fc);
    focls_opnd_t a, b;
    focls_src_t s, sb;
    logic [2:0] st;
    logic two, f, ia, sd, dm, pd;
    a = mk(ca);
    b = mk(cb);
    s = focls_src_t'(4'($urandom));
    st = 3'($urandom);
    two = 1'($urandom);
    {sb, sd, dm, pd} = 7'($urandom);
    f = iv && op >= FLOAT_OP_LO && op <= FLOAT_OP_HI;
    ia = bad(ca, a) || (two && bad(cb, b));
    @(posedge core_clk);
    {instValid, opcodeByte, twoOperands, srcA, opndA, opndB, stackTop, flagsClear} <=
      {iv, op, two, s, a, b, st, fc};
    {srcB, shortDenormSrc, denormMasked, pseudoDen} <= {sb, sd, dm, pd};
    fInv = (f && ia) || (!fc && fInv);
    fDen = (f && (ca inside {1, 2} || (two && cb inside {1, 2}) || sd)) || (!fc && fDen);
    q.push_back('{cyc + 2, f, focls_class_t'(9'h001 << ca), two ? focls_class_t'(9'h001 << cb)
      : CLS_ZERO, s.fromMem ? IDX_ZERO : 3'(st + s.stackIdx), f && !ia, fInv,
      (sb.fromMem || !two) ? IDX_ZERO : 3'(st + sb.stackIdx), f && two, f && sd && dm, fDen,
      {ca inside {7, 8} && a.fraction[FRAC_TOP], bad(ca, a), ca inside {1, 2}}});
  endtask : step
  // verdict and end of run, shared with the timeout
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  // scoreboard: settled outputs against the oldest due note
  always @(negedge core_clk) begin
    while (q.size() > 0 && q[0].due == cyc) begin
      e = q.pop_front();
      `CHK("floatOpValid", e.fop, floatOpValid)
      `CHK("resA.cls", e.ca, resA.cls)
      `CHK("resB.cls", e.cb, resB.cls)
      `CHK("physIdxA", e.pa, physIdxA)
      `CHK("computeEn", e.ce, computeEn)
      `CHK("statusFlags", e.fi, statusFlags.invalid)
      `CHK("immExtract", 1'b0, immExtract)
      `CHK("resA.flags", e.fa, {resA.quietNan, resA.invalid, resA.denormal})
      `CHK("physIdxB", e.pb, physIdxB)
      `CHK("opndBUsed", e.ub, opndBUsed)
      `CHK("normalizeReq", e.nr, normalizeReq)
      `CHK("statusDen", e.fd, statusFlags.denormal)
    end
    if (rDue) begin
      rExp = rPrev;
      if (rPrev.exponent == EXP_ZERO && rPrev.intBit) rExp.exponent = EXP_MIN_NORM;
      `CHK("resultOut", rExp, resultOut)
    end
  end
  // core result and reset level the classifier took at this edge
  always @(posedge core_clk) begin
    rPrev <= resultIn;
    rDue <= rst_n;
  end
  // cycle count and hang ceiling, far above the ~360 cycles of the run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      summarize();
    end
  end
  // reset, then class sweep, flag clear and random traffic back to back
  initial begin
    {instValid, opcodeByte, twoOperands, srcA, srcB, opndA, opndB, stackTop} = '0;
    {shortDenormSrc, denormMasked, flagsClear, pseudoDen} = '0;
    void'($urandom(39028));
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (ops[i]) for (int c = 0; c < 9; c++) step(1, ops[i], c, $urandom_range(8), 1'($urandom));
    $display("test class_sweep done");
    step(1, 8'hD9, 8, 0, 0);
    step(0, 8'hD9, 0, 0, 1);
    step(1, 8'hDE, 0, 0, 0);
    $display("test flag_clear done");
    repeat (300) step(1'($urandom), 8'($urandom_range(8'hE7, 8'hD0)), $urandom_range(8),
      $urandom_range(8), 1'($urandom));
    $display("test random done");
    repeat (3) @(posedge core_clk);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
